// ---- src/ibf_defs.svh ----
// Constants for the two-wire bus framing block: byte layout and bit timing.
// Assumes inclusion by bare name from every design file that needs a figure.
`ifndef IBF_DEFS_SVH
`define IBF_DEFS_SVH

`define IBF_BYTE_BITS   8
`define IBF_ADDR_BITS   7
`define IBF_RW_READ     1'b1
`define IBF_SYS_HZ      20000000
`define IBF_SCL_HZ      100000
// Quarter of one serial clock period in system clock cycles (rounds down: faster never slower)
`define IBF_QTR_CYC     (`IBF_SYS_HZ / (4 * `IBF_SCL_HZ))
`define IBF_DEV_ADDR    7'h20
`define IBF_CNT_ZERO    4'h0
`define IBF_PH_LAST     2'h3

`endif

// ---- src/ibf_pkg.sv ----
// Types shared by both ends of the two-wire bus framing block.
// Assumes nothing beyond a SystemVerilog compiler.
package ibf_pkg;

  // Device end, on the link clock
  typedef enum logic [2:0] {
    SL_IDLE, SL_ADDR, SL_ADDR_ACK, SL_RX, SL_RX_ACK, SL_TX, SL_TX_ACK, SL_IGNORE
  } ibf_sl_state_e;

  // Master end, on the system clock
  typedef enum logic [1:0] {
    MS_IDLE, MS_START, MS_STOP, MS_BIT
  } ibf_ms_state_e;

  // Master commands
  typedef enum logic [1:0] {
    OP_START, OP_STOP, OP_WRITE, OP_READ
  } ibf_op_e;

endpackage : ibf_pkg

// ---- src/ibf_if.sv ----
// Two-wire bus between the master end and the device end.
// Open-drain: a line reads low while any party enables a low drive.
`timescale 1ns/1ps
`default_nettype none

interface ibf_if;
  logic scl_m_o;   // Master clock drive value
  logic scl_m_oe;  // Master clock drive enable
  logic sda_m_o;   // Master data drive value
  logic sda_m_oe;  // Master data drive enable
  logic sda_s_o;   // Device data drive value
  logic sda_s_oe;  // Device data drive enable
  logic scl;       // Resolved clock line
  logic sda;       // Resolved data line

  assign scl = ~(scl_m_oe & ~scl_m_o);
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));

  modport master (output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe, input scl, sda);
  modport slave  (output sda_s_o, sda_s_oe, input scl, sda);
endinterface : ibf_if

`default_nettype wire

// ---- src/ibf_cond_det.sv ----
// Line synchroniser and bus event detector for the device end.
// Assumes raw line levels from another clock domain; clk oversamples the bus.
`timescale 1ns/1ps
`default_nettype none

module ibf_cond_det (
  input  wire logic clk,       // Oversampling clock
  input  wire logic rst_n,     // Asynchronous reset, active low
  input  wire logic scl_in,    // Raw clock line
  input  wire logic sda_in,    // Raw data line
  output logic      sda_lvl,   // Synchronised data level
  output logic      start_p,   // Start condition seen
  output logic      stop_p,    // Stop condition seen
  output logic      scl_rise,  // Clock line rose
  output logic      scl_fall   // Clock line fell
);
  logic scl_m1_ff, scl_m2_ff, scl_d_ff;
  logic sda_m1_ff, sda_m2_ff, sda_d_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_m1_ff <= 1'b1;
      scl_m2_ff <= 1'b1;
      scl_d_ff  <= 1'b1;
      sda_m1_ff <= 1'b1;
      sda_m2_ff <= 1'b1;
      sda_d_ff  <= 1'b1;
    end else begin
      scl_m1_ff <= scl_in;
      scl_m2_ff <= scl_m1_ff;
      scl_d_ff  <= scl_m2_ff;
      sda_m1_ff <= sda_in;
      sda_m2_ff <= sda_m1_ff;
      sda_d_ff  <= sda_m2_ff;
    end
  end

  // Data moving while the clock stays high is control, never data
  assign start_p  = scl_m2_ff & scl_d_ff & sda_d_ff & ~sda_m2_ff;
  assign stop_p   = scl_m2_ff & scl_d_ff & ~sda_d_ff & sda_m2_ff;
  assign scl_rise = scl_m2_ff & ~scl_d_ff;
  assign scl_fall = ~scl_m2_ff & scl_d_ff;
  assign sda_lvl  = sda_m2_ff;
endmodule : ibf_cond_det

`default_nettype wire

// ---- src/ibf_slave.sv ----
// Device end of the two-wire bus: address match, byte receive and transmit.
// Assumes LINK_CLK oversamples the bus at least eight times per clock phase;
// CLK_SYS user side is unrelated in phase. Clock stretching is never used.
`timescale 1ns/1ps
`default_nettype none
`include "ibf_defs.svh"

// Overview of operation
// - Master starts transfers only on idle bus
// - One data bit per clock pulse
// - Data stable while clock high; changes are conditions
// - Both lines high means bus idle
// - Data falling, clock high: start
// - Data rising, clock high: stop, idle
// - Unlimited bytes between start and stop
// - Eight bits then one acknowledge slot
// - Transmitter releases data in acknowledge slot
// - Device acknowledges every received byte; this device leaves an address byte other than DEV_ADDR unacknowledged
// - Master acknowledges read bytes except last
// - Acknowledger holds data low through clock high
// - Master ends read by not acknowledging
// - After no-acknowledge transmitter releases data line
// - Write: address with low bit 0, command
// - Read: repeated start, address low bit 1
module ibf_slave
  import ibf_pkg::*;
#(
  parameter logic [`IBF_ADDR_BITS-1:0] DEV_ADDR = `IBF_DEV_ADDR
) (
  input  wire logic       LINK_CLK,   // Bus oversampling clock
  input  wire logic       CLK_SYS,    // User side clock
  input  wire logic       RST_N,      // Asynchronous reset, active low
  ibf_if.slave            BUS,        // Two-wire bus
  input  wire logic [7:0] TX_DATA,    // Byte offered for reads
  input  wire logic       TX_LOAD,    // Capture TX_DATA
  output logic      [7:0] RX_DATA,    // Received byte
  output logic            RX_VALID,   // RX_DATA new, one cycle
  output logic            RX_IS_CMD,  // RX_DATA is the command byte
  output logic            TX_REQ,     // Offered byte taken, supply next
  output logic            BUSY        // Transfer addressed to us active
);
  localparam logic [3:0] BYTE_END = 4'(`IBF_BYTE_BITS);
  localparam logic [3:0] TX_LAST  = 4'(`IBF_BYTE_BITS - 1);

  // ************************************************************
  // Link side framing
  // ************************************************************
  ibf_sl_state_e state_ff;
  logic [3:0]    cnt_ff;
  logic [7:0]    shift_ff;
  logic          sda_oe_ff;
  logic          rw_ff;
  logic          nack_ff;
  logic          first_ff;
  logic [7:0]    rx_byte_ff;
  logic          rx_cmd_ff;
  logic          rx_tog_ff;
  logic          tx_tog_ff;
  logic [7:0]    tx_byte_ff;
  logic          sda_lvl, start_p, stop_p, scl_rise, scl_fall;

  ibf_cond_det u_det (
    .clk      (LINK_CLK),
    .rst_n    (RST_N),
    .scl_in   (BUS.scl),
    .sda_in   (BUS.sda),
    .sda_lvl  (sda_lvl),
    .start_p  (start_p),
    .stop_p   (stop_p),
    .scl_rise (scl_rise),
    .scl_fall (scl_fall)
  );

  always_ff @(posedge LINK_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff  <= SL_IDLE;
      cnt_ff    <= `IBF_CNT_ZERO;
      shift_ff  <= 8'h00;
      sda_oe_ff <= 1'b0;
      rw_ff     <= 1'b0;
      nack_ff   <= 1'b0;
      first_ff  <= 1'b0;
    end else if (stop_p) begin
      state_ff  <= SL_IDLE;
      sda_oe_ff <= 1'b0;
    end else if (start_p) begin
      // Also a repeated start: any byte in flight is dropped
      state_ff  <= SL_ADDR;
      cnt_ff    <= `IBF_CNT_ZERO;
      sda_oe_ff <= 1'b0;
    end else begin
      case (state_ff)
        SL_IDLE: begin
          sda_oe_ff <= 1'b0;
        end
        SL_ADDR, SL_RX: begin
          if (scl_rise && cnt_ff != BYTE_END) begin
            shift_ff <= {shift_ff[6:0], sda_lvl};
            cnt_ff   <= cnt_ff + 4'h1;
          end else if (scl_fall && cnt_ff == BYTE_END) begin
            if (state_ff == SL_RX) begin
              sda_oe_ff <= 1'b1;
              state_ff  <= SL_RX_ACK;
            end else if (shift_ff[7:1] == DEV_ADDR) begin
              sda_oe_ff <= 1'b1;
              rw_ff     <= shift_ff[0];
              first_ff  <= (shift_ff[0] != `IBF_RW_READ);
              state_ff  <= SL_ADDR_ACK;
            end else begin
              state_ff  <= SL_IGNORE;
            end
          end
        end
        SL_ADDR_ACK: begin
          if (scl_fall) begin
            cnt_ff <= `IBF_CNT_ZERO;
            if (rw_ff == `IBF_RW_READ) begin
              sda_oe_ff <= ~tx_byte_ff[7];
              shift_ff  <= {tx_byte_ff[6:0], 1'b1};
              state_ff  <= SL_TX;
            end else begin
              sda_oe_ff <= 1'b0;
              state_ff  <= SL_RX;
            end
          end
        end
        SL_RX_ACK: begin
          // No byte limit: keep receiving until a condition ends it
          if (scl_fall) begin
            sda_oe_ff <= 1'b0;
            cnt_ff    <= `IBF_CNT_ZERO;
            first_ff  <= 1'b0;
            state_ff  <= SL_RX;
          end
        end
        SL_TX: begin
          if (scl_fall) begin
            if (cnt_ff == TX_LAST) begin
              sda_oe_ff <= 1'b0;
              state_ff  <= SL_TX_ACK;
            end else begin
              sda_oe_ff <= ~shift_ff[7];
              shift_ff  <= {shift_ff[6:0], 1'b1};
              cnt_ff    <= cnt_ff + 4'h1;
            end
          end
        end
        SL_TX_ACK: begin
          if (scl_rise) begin
            nack_ff <= sda_lvl;
          end else if (scl_fall) begin
            cnt_ff <= `IBF_CNT_ZERO;
            if (nack_ff) begin
              sda_oe_ff <= 1'b0;
              state_ff  <= SL_IGNORE;
            end else begin
              sda_oe_ff <= ~tx_byte_ff[7];
              shift_ff  <= {tx_byte_ff[6:0], 1'b1};
              state_ff  <= SL_TX;
            end
          end
        end
        SL_IGNORE: begin
          sda_oe_ff <= 1'b0;
        end
        default: begin
          state_ff  <= SL_IDLE;
          sda_oe_ff <= 1'b0;
        end
      endcase
    end
  end

  assign BUS.sda_s_o  = 1'b0;
  assign BUS.sda_s_oe = sda_oe_ff;

  // Received byte is posted on the acknowledge fall and stays put for a
  // whole byte time, long enough for the toggle to cross
  always_ff @(posedge LINK_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rx_byte_ff <= 8'h00;
      rx_cmd_ff  <= 1'b0;
      rx_tog_ff  <= 1'b0;
    end else if (!start_p && !stop_p && state_ff == SL_RX_ACK && scl_fall) begin
      rx_byte_ff <= shift_ff;
      rx_cmd_ff  <= first_ff;
      rx_tog_ff  <= ~rx_tog_ff;
    end
  end

  // Each load of a transmit byte asks the user for the next one
  always_ff @(posedge LINK_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tx_tog_ff <= 1'b0;
    end else if (!start_p && !stop_p && scl_fall &&
                 ((state_ff == SL_ADDR_ACK && rw_ff == `IBF_RW_READ) ||
                  (state_ff == SL_TX_ACK && !nack_ff))) begin
      tx_tog_ff <= ~tx_tog_ff;
    end
  end

  // ************************************************************
  // Crossings between the two clocks
  // ************************************************************
  logic [7:0] tx_hold_ff;
  logic       ld_tog_ff, ld_m1_ff, ld_m2_ff, ld_d_ff;
  logic       rx_m1_ff, rx_m2_ff, rx_d_ff;
  logic       tq_m1_ff, tq_m2_ff, tq_d_ff;
  logic       bz_m1_ff, bz_m2_ff;
  logic       busy_lnk_ff;

  // User byte held stable on system side; toggle tells the link to copy
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      tx_hold_ff <= 8'hFF;
      ld_tog_ff  <= 1'b0;
    end else if (TX_LOAD) begin
      tx_hold_ff <= TX_DATA;
      ld_tog_ff  <= ~ld_tog_ff;
    end
  end

  always_ff @(posedge LINK_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ld_m1_ff   <= 1'b0;
      ld_m2_ff   <= 1'b0;
      ld_d_ff    <= 1'b0;
      tx_byte_ff <= 8'hFF;
    end else begin
      ld_m1_ff <= ld_tog_ff;
      ld_m2_ff <= ld_m1_ff;
      ld_d_ff  <= ld_m2_ff;
      if (ld_m2_ff != ld_d_ff) begin
        tx_byte_ff <= tx_hold_ff;
      end
    end
  end

  always_ff @(posedge LINK_CLK or negedge RST_N) begin
    if (!RST_N) begin
      busy_lnk_ff <= 1'b0;
    end else begin
      busy_lnk_ff <= (state_ff != SL_IDLE) && (state_ff != SL_IGNORE) && (state_ff != SL_ADDR);
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rx_m1_ff  <= 1'b0;
      rx_m2_ff  <= 1'b0;
      rx_d_ff   <= 1'b0;
      tq_m1_ff  <= 1'b0;
      tq_m2_ff  <= 1'b0;
      tq_d_ff   <= 1'b0;
      bz_m1_ff  <= 1'b0;
      bz_m2_ff  <= 1'b0;
      RX_DATA   <= 8'h00;
      RX_IS_CMD <= 1'b0;
      RX_VALID  <= 1'b0;
      TX_REQ    <= 1'b0;
      BUSY      <= 1'b0;
    end else begin
      rx_m1_ff <= rx_tog_ff;
      rx_m2_ff <= rx_m1_ff;
      rx_d_ff  <= rx_m2_ff;
      tq_m1_ff <= tx_tog_ff;
      tq_m2_ff <= tq_m1_ff;
      tq_d_ff  <= tq_m2_ff;
      bz_m1_ff <= busy_lnk_ff;
      bz_m2_ff <= bz_m1_ff;
      BUSY     <= bz_m2_ff;
      RX_VALID <= rx_m2_ff != rx_d_ff;
      TX_REQ   <= tq_m2_ff != tq_d_ff;
      if (rx_m2_ff != rx_d_ff) begin
        RX_DATA   <= rx_byte_ff;
        RX_IS_CMD <= rx_cmd_ff;
      end
    end
  end
endmodule : ibf_slave

`default_nettype wire

// ---- src/ibf_master.sv ----
// Master end of the two-wire bus: makes the serial clock by dividing CLK_SYS.
// Assumes a single master on the bus and a device that never stretches SCL.
`timescale 1ns/1ps
`default_nettype none
`include "ibf_defs.svh"

module ibf_master
  import ibf_pkg::*;
#(
  parameter int QTR_CYC = `IBF_QTR_CYC
) (
  input  wire logic       CLK_SYS,    // System clock
  input  wire logic       RST_N,      // Asynchronous reset, active low
  ibf_if.master           BUS,        // Two-wire bus
  input  wire logic       CMD_VALID,  // Command offered
  input  wire ibf_op_e    CMD_OP,     // Start, stop, write or read
  input  wire logic [7:0] CMD_DATA,   // Byte to write
  input  wire logic       CMD_NACK,   // Read: last byte, leave unacknowledged
  output logic            CMD_READY,  // Command may be taken
  output logic            RSP_VALID,  // Byte finished, one cycle
  output logic      [7:0] RSP_DATA,   // Byte read or written
  output logic            RSP_NACK,   // Acknowledge slot read high
  output logic            BUSY        // Between own start and stop
);
  localparam logic [3:0] ACK_IDX = 4'(`IBF_BYTE_BITS);

  ibf_ms_state_e state_ff;
  logic [15:0]   qcnt_ff;
  logic [1:0]    ph_ff;
  logic [3:0]    idx_ff;
  logic [7:0]    shift_ff;
  logic          rd_ff, nack_req_ff, ack_in_ff;
  logic          scl_oe_ff, sda_oe_ff;
  logic          sda_m1_ff, sda_m2_ff;
  logic          tick;

  // ************************************************************
  // Quarter-period timebase and line sampling
  // ************************************************************
  assign tick = (qcnt_ff == 16'(QTR_CYC - 1));

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      qcnt_ff <= 16'h0000;
    end else if (state_ff == MS_IDLE || tick) begin
      qcnt_ff <= 16'h0000;
    end else begin
      qcnt_ff <= qcnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      sda_m1_ff <= 1'b1;
      sda_m2_ff <= 1'b1;
    end else begin
      sda_m1_ff <= BUS.sda;
      sda_m2_ff <= sda_m1_ff;
    end
  end

  // ************************************************************
  // Command sequencer
  // ************************************************************
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      state_ff    <= MS_IDLE;
      ph_ff       <= 2'h0;
      idx_ff      <= `IBF_CNT_ZERO;
      shift_ff    <= 8'h00;
      rd_ff       <= 1'b0;
      nack_req_ff <= 1'b0;
      ack_in_ff   <= 1'b0;
      scl_oe_ff   <= 1'b0;
      sda_oe_ff   <= 1'b0;
      CMD_READY   <= 1'b1;
      RSP_VALID   <= 1'b0;
      RSP_DATA    <= 8'h00;
      RSP_NACK    <= 1'b0;
      BUSY        <= 1'b0;
    end else begin
      RSP_VALID <= 1'b0;
      case (state_ff)
        MS_IDLE: begin
          if (CMD_VALID && CMD_READY) begin
            CMD_READY   <= 1'b0;
            ph_ff       <= 2'h0;
            idx_ff      <= `IBF_CNT_ZERO;
            shift_ff    <= CMD_DATA;
            rd_ff       <= (CMD_OP == OP_READ);
            nack_req_ff <= CMD_NACK;
            case (CMD_OP)
              OP_START: state_ff <= MS_START;
              OP_STOP:  state_ff <= MS_STOP;
              default:  state_ff <= MS_BIT;
            endcase
          end
        end
        MS_START: begin
          if (tick) begin
            ph_ff <= ph_ff + 2'h1;
            case (ph_ff)
              2'h0: sda_oe_ff <= 1'b0;
              2'h1: scl_oe_ff <= 1'b0;
              2'h2: sda_oe_ff <= 1'b1;
              default: begin
                scl_oe_ff <= 1'b1;
                BUSY      <= 1'b1;
                state_ff  <= MS_IDLE;
                CMD_READY <= 1'b1;
              end
            endcase
          end
        end
        MS_STOP: begin
          if (tick) begin
            ph_ff <= ph_ff + 2'h1;
            case (ph_ff)
              2'h0: sda_oe_ff <= 1'b1;
              2'h1: scl_oe_ff <= 1'b0;
              2'h2: sda_oe_ff <= 1'b0;
              default: begin
                BUSY      <= 1'b0;
                state_ff  <= MS_IDLE;
                CMD_READY <= 1'b1;
              end
            endcase
          end
        end
        MS_BIT: begin
          if (tick) begin
            ph_ff <= ph_ff + 2'h1;
            case (ph_ff)
              2'h0: begin
                // Data only changes while the clock is low
                if (idx_ff != ACK_IDX) begin
                  sda_oe_ff <= !rd_ff && !shift_ff[7];
                end else begin
                  sda_oe_ff <= rd_ff && !nack_req_ff;
                end
              end
              2'h1: scl_oe_ff <= 1'b0;
              2'h2: begin
                if (idx_ff != ACK_IDX) begin
                  shift_ff <= {shift_ff[6:0], sda_m2_ff};
                end else begin
                  ack_in_ff <= sda_m2_ff;
                end
              end
              default: begin
                scl_oe_ff <= 1'b1;
                if (idx_ff == ACK_IDX) begin
                  sda_oe_ff <= 1'b0;
                  RSP_VALID <= 1'b1;
                  RSP_DATA  <= shift_ff;
                  RSP_NACK  <= ack_in_ff;
                  state_ff  <= MS_IDLE;
                  CMD_READY <= 1'b1;
                end else begin
                  idx_ff <= idx_ff + 4'h1;
                end
              end
            endcase
          end
        end
        default: begin
          state_ff  <= MS_IDLE;
          CMD_READY <= 1'b1;
        end
      endcase
    end
  end

  assign BUS.scl_m_o  = 1'b0;
  assign BUS.scl_m_oe = scl_oe_ff;
  assign BUS.sda_m_o  = 1'b0;
  assign BUS.sda_m_oe = sda_oe_ff;
endmodule : ibf_master

`default_nettype wire

// ---- bench/ibf_bus_checker.sv ----
// Assertions on the two-wire bus between the master end and the device end.
// Assumes plain interface signals, six-cycle quarters on CLK_SYS, device on LINK_CLK.
`timescale 1ns/1ps
`default_nettype none

module ibf_bus_checker (
  input  wire logic CLK_SYS,   // Master clock
  input  wire logic LINK_CLK,  // Device clock
  input  wire logic RST_N,     // Reset, active low
  input  wire logic scl_m_o,   // Master clock value
  input  wire logic scl_m_oe,  // Master clock enable
  input  wire logic sda_m_o,   // Master data value
  input  wire logic sda_m_oe,  // Master data enable
  input  wire logic sda_s_o,   // Device data value
  input  wire logic sda_s_oe,  // Device data enable
  input  wire logic scl,       // Clock line
  input  wire logic sda        // Data line
);
  // ****************
  // Frame tracking
  // ****************
  logic       scl_ff;
  logic       sda_ff;
  logic       open_ff;
  logic [3:0] bit_ff;
  logic       start_c;
  logic       stop_c;
  logic       nack_c;

  assign start_c = scl & scl_ff & sda_ff & ~sda;
  assign stop_c  = scl & scl_ff & ~sda_ff & sda;
  assign nack_c  = scl & ~scl_ff & (bit_ff == 4'h8) & sda;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
    end else begin
      scl_ff <= scl;
      sda_ff <= sda;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N)
      open_ff <= 1'b0;
    else if (start_c)
      open_ff <= 1'b1;
    else if (stop_c)
      open_ff <= 1'b0;
  end

  // Pulses modulo nine; a stop or a restart adds one rise of its own
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N)
      bit_ff <= 4'h0;
    else if (start_c)
      bit_ff <= 4'h0;
    else if (scl & ~scl_ff)
      bit_ff <= (bit_ff == 4'h8) ? 4'h0 : bit_ff + 4'h1;
  end

  // ****************
  // Properties
  // ****************
  sequence hi_run_s;
    scl [*8];
  endsequence

  sequence lo_run_s;
    !scl [*8];
  endsequence

  drive_low_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !(scl_m_o | sda_m_o | sda_s_o)) else $error("open drain value not low");
  idle_free_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !open_ff |-> !sda_s_oe) else $error("device pulls data outside a frame");
  idle_scl_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !open_ff |-> !scl_m_oe) else $error("master holds clock low outside a frame");
  frame_bits_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (stop_c | (start_c & open_ff)) |-> bit_ff == 4'h1) else $error("frame not whole bytes plus ack");
  high_len_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    $rose(scl) |-> hi_run_s) else $error("clock high phase too short");
  low_len_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    $fell(scl) |-> lo_run_s) else $error("clock low phase too short");
  no_clash_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (scl & scl_ff) |-> !(sda_m_oe & sda_s_oe)) else $error("both ends drive data in clock high");
  nack_release_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    nack_c |-> ##10 !sda_s_oe [*8]) else $error("device drives after no-acknowledge");
  dev_setup_a: assert property (@(posedge LINK_CLK) disable iff (!RST_N)
    $rose(sda_s_oe) |-> !scl) else $error("device changes data in clock high");
  dev_hold_a: assert property (@(posedge LINK_CLK) disable iff (!RST_N)
    ($rose(scl) && sda_s_oe) |-> sda_s_oe [*8]) else $error("device low not held through high");
endmodule : ibf_bus_checker

`default_nettype wire

// ---- bench/tb_top.sv ----
// Bench: master end and device end joined by the bus interface, with the checker.
// Assumes the package, interface and both ends compiled first; quarters of six cycles.
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import ibf_pkg::*;
;
  logic       clk_sys;
  logic       link_clk;
  logic       rst_n;
  logic       cmd_valid;
  ibf_op_e    cmd_op;
  logic [7:0] cmd_data;
  logic       cmd_nack;
  logic       cmd_ready;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  logic       rsp_nack;
  logic       m_busy;
  logic [7:0] tx_data;
  logic       tx_load;
  logic [7:0] rx_data;
  logic       rx_valid;
  logic       rx_is_cmd;
  logic       tx_req;
  logic       s_busy;
  logic [8:0] rx_q[$];
  logic [7:0] tx_q[$];
  logic [7:0] wdat[4] = '{8'hA5, 8'h3C, 8'h00, 8'hFF};
  int         fail_count;
  int         checked;
  int         cyc;

  ibf_if bus ();
  ibf_master #(.QTR_CYC(6)) u_ibf_master (.CLK_SYS(clk_sys), .RST_N(rst_n), .BUS(bus),
    .CMD_VALID(cmd_valid), .CMD_OP(cmd_op), .CMD_DATA(cmd_data), .CMD_NACK(cmd_nack),
    .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .RSP_NACK(rsp_nack),
    .BUSY(m_busy));
  ibf_slave u_ibf_slave (.LINK_CLK(link_clk), .CLK_SYS(clk_sys), .RST_N(rst_n), .BUS(bus),
    .TX_DATA(tx_data), .TX_LOAD(tx_load), .RX_DATA(rx_data), .RX_VALID(rx_valid),
    .RX_IS_CMD(rx_is_cmd), .TX_REQ(tx_req), .BUSY(s_busy));
  ibf_bus_checker u_ibf_bus_checker (.CLK_SYS(clk_sys), .LINK_CLK(link_clk), .RST_N(rst_n),
    .scl_m_o(bus.scl_m_o), .scl_m_oe(bus.scl_m_oe), .sda_m_o(bus.sda_m_o),
    .sda_m_oe(bus.sda_m_oe), .sda_s_o(bus.sda_s_o), .sda_s_oe(bus.sda_s_oe),
    .scl(bus.scl), .sda(bus.sda));

  // ****************
  // Clocks, user side helpers, timeout
  // ****************
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Odd offset keeps the link clock unrelated in phase
  initial begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end

  // Offer the next read byte whenever the device asks
  always @(negedge clk_sys) begin
    tx_load = 1'b0;
    if (tx_req === 1'b1 && tx_q.size() > 0) begin
      tx_data = tx_q.pop_front();
      tx_load = 1'b1;
    end
  end

  // Negedge: the one-cycle strobe is settled here, never racing its own launch edge
  always @(negedge clk_sys) begin
    if (rx_valid === 1'b1)
      rx_q.push_back({rx_is_cmd, rx_data});
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      give_verdict();
    end
  end

  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cmd(input ibf_op_e op, input logic [7:0] d, input logic nk);
    int n;
    cmd_op = op;
    cmd_data = d;
    cmd_nack = nk;
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    n = 0;
    while (cmd_ready === 1'b1 && n < 4) begin
      @(negedge clk_sys);
      n++;
    end
    while (cmd_ready !== 1'b1 && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 400)
      chk(10'h000, 10'h3FF);
  endtask : cmd

  task automatic wr(input logic [7:0] d, input logic nk);
    cmd(OP_WRITE, d, 1'b0);
    chk({rsp_valid, rsp_nack, rsp_data}, {1'b1, nk, d});
  endtask : wr

  task automatic rd(input logic nk, input logic [7:0] e);
    cmd(OP_READ, 8'h00, nk);
    chk({rsp_valid, rsp_nack, rsp_data}, {1'b1, nk, e});
  endtask : rd

  task automatic rx_chk(input logic [8:0] e);
    logic [9:0] g;
    g = (rx_q.size() > 0) ? {1'b0, rx_q.pop_front()} : 10'h3FF;
    chk(g, {1'b0, e});
  endtask : rx_chk

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // ****************
  // Main sequence
  // ****************
  initial begin
    {cmd_valid, cmd_data, cmd_nack, tx_data, tx_load} = '0;
    cmd_op = OP_START;
    fail_count = 0;
    checked = 0;
    cyc = 0;
    rst_n = 1'b0;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk({6'h00, s_busy, m_busy, bus.scl, bus.sda}, 10'h003);
    // Long write: address, command, then four data bytes
    cmd(OP_START, 8'h00, 1'b0);
    wr(8'h40, 1'b0);
    chk({9'h000, s_busy}, 10'h001);
    wr(8'h06, 1'b0);
    for (int i = 0; i < 4; i++)
      wr(wdat[i], 1'b0);
    cmd(OP_STOP, 8'h00, 1'b0);
    repeat (10) @(negedge clk_sys);
    chk({6'h00, s_busy, m_busy, bus.scl, bus.sda}, 10'h003);
    rx_chk(9'h106);
    for (int i = 0; i < 4; i++)
      rx_chk({1'b0, wdat[i]});
    // Read through a repeated start; reset byte first, then the loaded one
    cmd(OP_START, 8'h00, 1'b0);
    wr(8'h40, 1'b0);
    wr(8'h02, 1'b0);
    tx_q.push_back(8'hC3);
    cmd(OP_START, 8'h00, 1'b0);
    wr(8'h41, 1'b0);
    rd(1'b0, 8'hFF);
    rd(1'b1, 8'hC3);
    repeat (10) @(negedge clk_sys);
    chk({9'h000, s_busy}, 10'h000);
    cmd(OP_STOP, 8'h00, 1'b0);
    rx_chk(9'h102);
    // Without a new load the same byte goes out again
    cmd(OP_START, 8'h00, 1'b0);
    wr(8'h41, 1'b0);
    rd(1'b1, 8'hC3);
    cmd(OP_STOP, 8'h00, 1'b0);
    // Another address: no acknowledge, nothing received
    cmd(OP_START, 8'h00, 1'b0);
    wr(8'h42, 1'b1);
    wr(8'h11, 1'b1);
    cmd(OP_STOP, 8'h00, 1'b0);
    repeat (10) @(negedge clk_sys);
    chk(10'(rx_q.size()), 10'h000);
    give_verdict();
  end
endmodule : tb_top

`default_nettype wire
